/* tpc_pkg.sv */
/*
   Constants, field layouts and helper functions for the transmit phase
   compensation buffer.
   Assumes it is compiled before every other file of the block.
*/
// Contract
// RULE1 - Buffer words between fabric and parallel clocks
// RULE2 - Storage depth is exactly four words
// RULE3 - Normal mode latency is two to three cycles
// RULE4 - Registered mode adds one parallel clock cycle
// RULE5 - Word width selectable as 8, 10, 16, 20
// RULE6 - Fabric words flow on toward coding sublayer
// RULE7 - PCI Express mode takes words from PIPE side
// RULE8 - One word per clock, Gray pointers cross domains
package tpc_pkg;

   // ---------------------------------------------------------------
   // Geometry
   // ---------------------------------------------------------------
   localparam int DATA_W = 20;            // Widest channel word
   localparam int DEPTH  = 4;             // Buffer words
   localparam int ADDR_W = 2;             // Index into the buffer
   localparam int PTR_W  = 3;             // Index plus wrap bit

   // ---------------------------------------------------------------
   // Width selection codes
   // ---------------------------------------------------------------
   localparam logic [1:0] WIDTH_8  = 2'h0;
   localparam logic [1:0] WIDTH_10 = 2'h1;
   localparam logic [1:0] WIDTH_16 = 2'h2;
   localparam logic [1:0] WIDTH_20 = 2'h3;

   localparam logic [DATA_W-1:0] MASK_8  = 20'h0_00ff;
   localparam logic [DATA_W-1:0] MASK_10 = 20'h0_03ff;
   localparam logic [DATA_W-1:0] MASK_16 = 20'h0_ffff;
   localparam logic [DATA_W-1:0] MASK_20 = 20'hf_ffff;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [PTR_W-1:0]  PTR_RST  = 3'h0;
   localparam logic [DATA_W-1:0] DATA_RST = 20'h0_0000;

   // Lane mask for the selected word width
   function automatic logic [DATA_W-1:0] width_mask(input logic [1:0] sel);
      logic [DATA_W-1:0] m;
      m = MASK_20;
      unique case (sel)
         WIDTH_8  : m = MASK_8;
         WIDTH_10 : m = MASK_10;
         WIDTH_16 : m = MASK_16;
         WIDTH_20 : m = MASK_20;
      endcase
      return m;
   endfunction

   // Binary to Gray
   function automatic logic [PTR_W-1:0] bin2gray(input logic [PTR_W-1:0] b);
      return b ^ (b >> 1);
   endfunction

   // Gray to binary
   function automatic logic [PTR_W-1:0] gray2bin(input logic [PTR_W-1:0] g);
      logic [PTR_W-1:0] b;
      b = '0;
      b[PTR_W-1] = g[PTR_W-1];
      for (int i = PTR_W - 2; i >= 0; i--)
      begin
         b[i] = b[i+1] ^ g[i];
      end
      return b;
   endfunction

endpackage

/* tpc_sync.sv */
/*
   Two flip-flop synchroniser for a Gray-coded pointer.
   Assumes the input changes at most one bit per source clock edge.
*/
`timescale 1ns/1ps
module tpc_sync
   import tpc_pkg::*;
#(
   parameter int W = 3
)
(
   input  wire logic         clk_i,
   input  wire logic         reset_i,
   input  wire logic [W-1:0] d_i,
   output      logic [W-1:0] q_o
);

   logic [W-1:0] meta_q;

   // ---------------------------------------------------------------
   // Synchroniser stages
   // ---------------------------------------------------------------
   // First stage feeds only the second
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         meta_q <= '0;
         q_o    <= '0;
      end
      else
      begin
         meta_q <= d_i;
         q_o    <= meta_q;
      end
   end

endmodule

/* tpc_tx_phase_comp.sv */
/*
   Transmit phase compensation buffer: four-word asynchronous FIFO from the
   fabric interface clock to the channel parallel clock, plus a registered
   low-latency bypass for deterministic latency operation.
   Assumes width_sel_i, pipe_mode_i and reg_mode_i are static configuration,
   and that in registered mode fab_clk_i is the parallel clock itself.
*/
`timescale 1ns/1ps
module tpc_tx_phase_comp
   import tpc_pkg::*;
(
   input  wire logic              ref_clk_i,
   input  wire logic              fab_clk_i,
   input  wire logic              reset_i,
   input  wire logic [1:0]        width_sel_i,
   input  wire logic              pipe_mode_i,
   input  wire logic              reg_mode_i,
   input  wire logic [DATA_W-1:0] fab_data_i,
   input  wire logic [DATA_W-1:0] pipe_data_i,
   input  wire logic              fab_valid_i,
   output      logic              fab_ready_o,
   output      logic [DATA_W-1:0] pcs_data_o,
   output      logic              pcs_valid_o
);

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   logic [DATA_W-1:0] mem [DEPTH];
   logic [PTR_W-1:0]  wbin_q;
   logic [PTR_W-1:0]  wbin_d;
   logic [PTR_W-1:0]  wgray_q;
   logic [PTR_W-1:0]  rgray_s;
   logic [PTR_W-1:0]  rbin_q;
   logic [PTR_W-1:0]  rbin_d;
   logic [PTR_W-1:0]  rgray_q;
   logic [PTR_W-1:0]  wgray_s;
   logic [DATA_W-1:0] src_word;
   logic              push;
   logic              pop;
   logic              empty;
   logic              full_d;

   // ---------------------------------------------------------------
   // Write side, fabric interface clock
   // ---------------------------------------------------------------
   // Source select: PIPE words in PCI Express mode, else direct fabric
   assign src_word = pipe_mode_i ? pipe_data_i : fab_data_i;   // [RULE7] [RULE1]
   assign push     = fab_valid_i & fab_ready_o & ~reg_mode_i;  // [RULE8]
   assign wbin_d   = wbin_q + PTR_W'(push);
   // Full when next write pointer laps the synced read pointer
   assign full_d   = bin2gray(wbin_d) == {~rgray_s[PTR_W-1:PTR_W-2], rgray_s[PTR_W-3:0]}; // [RULE2]

   // Write pointer, binary and Gray
   always_ff @(posedge fab_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         wbin_q  <= PTR_RST;
         wgray_q <= PTR_RST;
      end
      else
      begin
         wbin_q  <= wbin_d;
         wgray_q <= bin2gray(wbin_d);                           // [RULE8]
      end
   end

   // Ready registered from the next-state full test
   always_ff @(posedge fab_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         fab_ready_o <= 1'b0;
      end
      else
      begin
         fab_ready_o <= ~full_d;                               // [RULE2]
      end
   end

   // Storage, four words, written only on the fabric clock
   always_ff @(posedge fab_clk_i)
   begin
      if (push)
      begin
         mem[wbin_q[ADDR_W-1:0]] <= src_word;                  // [RULE2] [RULE1]
      end
   end

   // Read pointer brought into the fabric domain
   tpc_sync #(
      .W (PTR_W)
   ) u_rptr_sync (
      .clk_i   (fab_clk_i),
      .reset_i (reset_i),
      .d_i     (rgray_q),
      .q_o     (rgray_s)
   );

   // ---------------------------------------------------------------
   // Read side, parallel clock
   // ---------------------------------------------------------------
   // Write pointer brought into the parallel domain
   tpc_sync #(
      .W (PTR_W)
   ) u_wptr_sync (
      .clk_i   (ref_clk_i),
      .reset_i (reset_i),
      .d_i     (wgray_q),
      .q_o     (wgray_s)
   );

   assign empty  = rgray_q == wgray_s;                         // [RULE8]
   assign pop    = ~empty & ~reg_mode_i;                       // [RULE3]
   assign rbin_d = rbin_q + PTR_W'(pop);

   // Read pointer, binary and Gray
   always_ff @(posedge ref_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         rbin_q  <= PTR_RST;
         rgray_q <= PTR_RST;
      end
      else
      begin
         rbin_q  <= rbin_d;
         rgray_q <= bin2gray(rbin_d);                           // [RULE8]
      end
   end

   // Output word toward the coding sublayer, masked to channel width
   always_ff @(posedge ref_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         pcs_data_o  <= DATA_RST;
         pcs_valid_o <= 1'b0;
      end
      else if (reg_mode_i)
      begin
         // Registered bypass: one parallel clock of latency
         pcs_data_o  <= src_word & width_mask(width_sel_i);    // [RULE4] [RULE5]
         pcs_valid_o <= fab_valid_i;                           // [RULE4]
      end
      else
      begin
         pcs_data_o  <= pop ? (mem[rbin_q[ADDR_W-1:0]] & width_mask(width_sel_i)) : DATA_RST; // [RULE5] [RULE6]
         pcs_valid_o <= pop;                                   // [RULE3] [RULE6]
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   // Fill level seen from the write side
   logic [PTR_W-1:0] fill_w;
   assign fill_w = wbin_q - gray2bin(rgray_s);

   // Arrival of a new word at the read side
   sequence s_word_arrives;
      $changed(wgray_s) && !reg_mode_i;
   endsequence

   sequence s_word_out;
      pcs_valid_o;
   endsequence

   property p_pop_gives_valid;
      @(posedge ref_clk_i) disable iff (reset_i)
      pop |=> pcs_valid_o;
   endproperty
   a_pop_gives_valid: assert property (p_pop_gives_valid) // [RULE1]
      else $error("Popped word not presented");

   property p_depth_limit;
      @(posedge fab_clk_i) disable iff (reset_i)
      fill_w <= PTR_W'(DEPTH);
   endproperty
   a_depth_limit: assert property (p_depth_limit) // [RULE2]
      else $error("Buffer holds more than four words");

   property p_full_at_four;
      @(posedge fab_clk_i) disable iff (reset_i)
      (fill_w == PTR_W'(DEPTH)) |-> !fab_ready_o;
   endproperty
   a_full_at_four: assert property (p_full_at_four) // [RULE2]
      else $error("Ready high with four words stored");

   property p_normal_latency;
      @(posedge ref_clk_i) disable iff (reset_i)
      s_word_arrives |=> s_word_out;
   endproperty
   a_normal_latency: assert property (p_normal_latency) // [RULE3]
      else $error("Arrived word not forwarded next cycle");

   property p_reg_latency;
      @(posedge ref_clk_i) disable iff (reset_i)
      (reg_mode_i && fab_valid_i) |=> pcs_valid_o && pcs_data_o ==
         ($past(src_word) & width_mask($past(width_sel_i)));
   endproperty
   a_reg_latency: assert property (p_reg_latency) // [RULE4]
      else $error("Registered mode latency is not one cycle");

   property p_width_clean;
      @(posedge ref_clk_i) disable iff (reset_i)
      ##1 ((pcs_data_o & ~width_mask($past(width_sel_i))) == DATA_RST);
   endproperty
   a_width_clean: assert property (p_width_clean) // [RULE5]
      else $error("Bits above selected width are set");

   property p_pipe_source;
      @(posedge ref_clk_i) disable iff (reset_i)
      (reg_mode_i && pipe_mode_i && fab_valid_i) |=>
         pcs_data_o == ($past(pipe_data_i) & width_mask($past(width_sel_i)));
   endproperty
   a_pipe_source: assert property (p_pipe_source) // [RULE7]
      else $error("PIPE word not selected in PCI Express mode");

   property p_fabric_source;
      @(posedge ref_clk_i) disable iff (reset_i)
      (reg_mode_i && !pipe_mode_i && fab_valid_i) |=>
         pcs_data_o == ($past(fab_data_i) & width_mask($past(width_sel_i)));
   endproperty
   a_fabric_source: assert property (p_fabric_source) // [RULE6]
      else $error("Fabric word not forwarded");

   property p_gray_step;
      @(posedge fab_clk_i) disable iff (reset_i)
      $changed(wgray_q) |-> $onehot(wgray_q ^ $past(wgray_q));
   endproperty
   a_gray_step: assert property (p_gray_step) // [RULE8]
      else $error("Write pointer moved more than one Gray bit");

   property p_one_per_clock;
      @(posedge ref_clk_i) disable iff (reset_i)
      $changed(rbin_q) |-> (rbin_q == $past(rbin_q) + PTR_W'(1));
   endproperty
   a_one_per_clock: assert property (p_one_per_clock) // [RULE8]
      else $error("Read pointer advanced by more than one");

endmodule

/* tpc_fab_src.sv */
/*
   Fabric-side source model: offers random words to the phase compensation
   buffer on the fabric interface clock.
   Assumes the bench gates it with run_i and sets hold_i while a word is refused.
*/
`timescale 1ns/1ps
module tpc_fab_src
   import tpc_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic              reset_i,
   input  wire logic              run_i,
   input  wire logic              hold_i,
   output      logic              valid_o,
   output      logic [DATA_W-1:0] fab_data_o,
   output      logic [DATA_W-1:0] pipe_data_o
);
   logic took_q;

   // ---------------------------------------------------------------
   // Acceptance tracking
   // ---------------------------------------------------------------
   // Word taken at this rising edge: offered and not refused
   always @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         took_q <= 1'b0;
      end
      else
      begin
         took_q <= valid_o && !hold_i;
      end
   end

   // ---------------------------------------------------------------
   // Word source
   // ---------------------------------------------------------------
   // Change at falling edge; a refused word stays put
   always @(negedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         valid_o     <= 1'b0;
         fab_data_o  <= 20'h0_0000;
         pipe_data_o <= 20'hf_ffff;
      end
      else if (!valid_o || took_q)
      begin
         valid_o     <= run_i && ($urandom % 4 != 0);
         fab_data_o  <= DATA_W'($urandom);
         pipe_data_o <= DATA_W'($urandom);
      end
   end
endmodule

/* tb_top.sv */
/*
   Self-checking bench for the transmit phase compensation buffer.
   Assumes the buffer modules and tpc_fab_src are compiled first.
*/
`timescale 1ns/1ps
module tb_top
   import tpc_pkg::*;
;
   logic              ref_clk = 1'b0;
   logic              fab_raw = 1'b0;
   logic              ref_run = 1'b1;
   logic              same    = 1'b0;
   logic              run     = 1'b0;
   logic              reset_i = 1'b1;
   logic [1:0]        width_sel = 2'h0;
   logic              pipe_mode = 1'b0;
   logic              reg_mode  = 1'b0;
   logic              fab_valid;
   logic              fab_ready;
   logic              pcs_valid;
   logic [DATA_W-1:0] fab_data;
   logic [DATA_W-1:0] pipe_data;
   logic [DATA_W-1:0] pcs_data;
   logic [DATA_W-1:0] exp_q[$];
   int                t_q[$];
   int                failures = 0;
   int                compares = 0;
   int                cyc      = 0;
   int                pushes   = 0;
   int                lat;
   wire               fab_clk = same ? ref_clk : fab_raw;

   // ---------------------------------------------------------------
   // Clocks, design and source
   // ---------------------------------------------------------------
   // Parallel clock can be stopped; fabric clock unrelated in phase
   always #2 if (ref_run) ref_clk = ~ref_clk;
   always #1.65 fab_raw = ~fab_raw;

   tpc_tx_phase_comp uut (.ref_clk_i(ref_clk), .fab_clk_i(fab_clk), .reset_i(reset_i),
      .width_sel_i(width_sel), .pipe_mode_i(pipe_mode), .reg_mode_i(reg_mode),
      .fab_data_i(fab_data), .pipe_data_i(pipe_data), .fab_valid_i(fab_valid),
      .fab_ready_o(fab_ready), .pcs_data_o(pcs_data), .pcs_valid_o(pcs_valid));

   tpc_fab_src src (.clk_i(fab_clk), .reset_i(reset_i), .run_i(run),
      .hold_i(!reg_mode && !fab_ready), .valid_o(fab_valid), .fab_data_o(fab_data),
      .pipe_data_o(pipe_data));

   // ---------------------------------------------------------------
   // Checking
   // ---------------------------------------------------------------
   // Lane mask of a width code
   function automatic logic [DATA_W-1:0] mask_of(input logic [1:0] w);
      return w[1] ? (w[0] ? 20'hf_ffff : 20'h0_ffff) : (w[0] ? 20'h0_03ff : 20'h0_00ff);
   endfunction

   task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
      compares++;
      if (seen !== exp)
      begin
         failures++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic test_done;
      $display("failures=%0d compares=%0d", failures, compares);
      if (failures == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // Record accepted words with their edge index
   always @(posedge fab_clk)
   begin
      if (!reset_i && fab_valid && (reg_mode || fab_ready))
      begin
         exp_q.push_back((pipe_mode ? pipe_data : fab_data) & mask_of(width_sel));
         t_q.push_back(reg_mode ? cyc : cyc + 1);   // Bypass counts from input cycle
         pushes++;
      end
   end

   always @(posedge ref_clk) cyc <= cyc + 1;

   // Compare words once settled, in write order
   always @(negedge ref_clk)
   begin
      if (!reset_i && pcs_valid === 1'b1)
      begin
         if (exp_q.size() == 0)
            check(DATA_W'(pcs_valid), 20'h0_0000);
         else
         begin
            check(pcs_data, exp_q.pop_front());
            lat = cyc - t_q.pop_front();
            if (reg_mode)
               check(DATA_W'(lat), 20'h0_0001);
            else if (same)
               check(DATA_W'(lat >= 2 && lat <= 3), 20'h0_0001);
         end
      end
      else if (!reset_i && !reg_mode)
      begin
         check(pcs_data, 20'h0_0000);
         check(DATA_W'(pcs_valid), 20'h0_0000);
      end
   end

   // One configuration: reset, stream n words or fill, then drain
   task automatic run_mode(input logic [1:0] w, input logic p, input logic r,
                           input logic s, input int n, input bit fill);
      int k;
      run = 1'b0;
      reset_i = 1'b1;
      width_sel = w;
      pipe_mode = p;
      reg_mode = r;
      same = s;
      ref_run = 1'b1;
      repeat (6) @(negedge ref_clk);
      exp_q.delete();
      t_q.delete();
      pushes = 0;
      reset_i = 1'b0;
      if (fill)
         ref_run = 1'b0;
      run = 1'b1;
      if (fill)
      begin
         repeat (40) @(negedge fab_clk);
         check(DATA_W'(pushes), 20'h0_0004);
         check(DATA_W'(fab_ready), 20'h0_0000);
         ref_run = 1'b1;
      end
      for (k = 0; k < 5000 && pushes < n; k++)
         @(negedge fab_clk);
      run = 1'b0;
      for (k = 0; k < 500 && exp_q.size() > 0; k++)
         @(negedge ref_clk);
      check(DATA_W'(exp_q.size()), 20'h0_0000);
      check(DATA_W'(pushes >= n), 20'h0_0001);
      if (pushes < n || exp_q.size() > 0)
         test_done();
   endtask

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial
   begin
      void'($urandom(32'h1d42a322));
      for (int i = 0; i < 8; i++)
         run_mode(i[2:1], i[0], 1'b0, 1'b0, 40, 1'b0);
      for (int i = 0; i < 4; i++)
         run_mode(i[1:0], i[0], 1'b1, 1'b1, 20, 1'b0);
      run_mode(2'($urandom), 1'($urandom), 1'b0, 1'b1, int'(10 + $urandom % 30), 1'b0);
      run_mode(2'h3, 1'b0, 1'b0, 1'b1, 30, 1'b0);
      run_mode(2'h1, 1'b1, 1'b0, 1'b0, 0, 1'b1);
      test_done();
   end

   // Hang guard
   initial
   begin
      #200000;
      failures++;
      test_done();
   end
endmodule
